// File: hdl/cijba_core.sv
/*
  Execution unit for compare-increment-jump (equal / not equal) and the
  BCD correction instruction, with a small control and status register port.
  Assumes the decode front end has fetched all operand bytes, read the
  destination, the source pointer and the byte it points at, and passes
  the address of the following instruction as pc_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cijba_consts.svh"

// Overview of operation
// RQ1 - Jump-on-equal subtracts source from destination; zero difference adds offset to PC.
// RQ2 - Nonzero difference on jump-on-equal continues after the three-byte instruction.
// RQ3 - Jump-on-not-equal branches only on nonzero difference, else falls through.
// RQ4 - Both variants increment the source pointer register by one.
// RQ5 - Neither compare-jump variant alters any condition flag.
// RQ6 - Jump-on-equal is opcode C2, three bytes, register dst, indirect source.
// RQ7 - Jump-on-not-equal is opcode D2 with the same layout and modes.
// RQ8 - Compare-jump takes 18 cycles when taken, 16 when not.
// RQ9 - Branch offset is signed 8-bit, reaching -128 to +127 bytes.
// RQ10 - BCD correction rewrites the byte as two packed BCD digits.
// RQ11 - After addition add 00, 06, 60 or 66; carry only for 60/66.
// RQ12 - After subtraction add 00, FA, A0 or 9A; carry only for A0/9A.
// RQ13 - Result for operands not from valid BCD arithmetic is undefined.
// RQ14 - Carry per table, zero on zero, sign is bit 7; D and H kept.
// RQ15 - BCD correction is two bytes, four cycles; 40 register, 41 indirect.
// RQ16 - Addition or subtraction table chosen by the last arithmetic's subtract flag.
module cijba_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic issue,
  input wire cijba_pkg::cijba_byte_t opcode,
  input wire cijba_pkg::cijba_byte_t dst_value,
  input wire cijba_pkg::cijba_byte_t src_value,
  input wire cijba_pkg::cijba_byte_t src_ptr,
  input wire cijba_pkg::cijba_byte_t branch_offset,
  input wire logic [15:0] pc_in,
  input wire cijba_pkg::cijba_byte_t flags_in,
  input wire logic sub_flag,
  input wire logic half_flag,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic busy,
  output logic done,
  output logic accept,
  output logic [15:0] pc_out,
  output logic pc_we,
  output logic [7:0] ptr_out,
  output logic ptr_we,
  output logic [7:0] dst_out,
  output logic dst_we,
  output logic dst_indirect,
  output logic [7:0] flags_out,
  output logic flags_we,
  output logic [7:0] reg_rdata
);
  import cijba_pkg::*;

  cijba_state_e state_q;
  cijba_state_e state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [7:0] ctrl_q;
  logic [7:0] status_q;
  logic [7:0] taken_cnt_q;
  logic [7:0] reg_rdata_q;
  logic is_jump_eq;
  logic is_jump_ne;
  logic is_jump;
  logic is_bcd;
  logic is_known;
  logic br_taken;
  logic [15:0] br_pc;
  logic [7:0] br_ptr;
  logic [7:0] bcd_value;
  logic bcd_carry;
  logic [7:0] bcd_flags;
  logic kind_jump_q;
  logic [15:0] pc_q;
  logic [7:0] ptr_q;
  logic [7:0] dst_q;
  logic dst_ind_q;
  logic [7:0] flags_q;
  logic taken_q;
  logic finish;
  logic take;
  logic bad_take;

  // Decode of the four opcodes this unit owns
  assign is_jump_eq = (opcode == `CIJBA_OP_JUMP_EQ); // RQ6
  assign is_jump_ne = (opcode == `CIJBA_OP_JUMP_NE); // RQ7
  assign is_jump = is_jump_eq || is_jump_ne;
  assign is_bcd = (opcode == `CIJBA_OP_BCD_REG) || (opcode == `CIJBA_OP_BCD_IND); // RQ15
  assign is_known = is_jump || is_bcd;

  // Issue is only honoured while idle and enabled
  assign accept = (state_q == CIJBA_IDLE) && ctrl_q[`CIJBA_CTRL_EN];
  assign take = issue && accept && is_known;
  assign bad_take = issue && accept && !is_known;

  cijba_branch_unit u_branch (
    .dst_value(dst_value),
    .src_value(src_value),
    .src_ptr(src_ptr),
    .branch_offset(branch_offset),
    .pc(pc_in),
    .jump_on_equal(is_jump_eq),
    .taken(br_taken),
    .pc_next(br_pc),
    .ptr_next(br_ptr)
  );

  cijba_bcd_adjust u_bcd (
    .value(dst_value),
    .carry_in(flags_in[`CIJBA_FLAG_C]),
    .half_in(half_flag),
    .after_sub(sub_flag),
    .result(bcd_value),
    .carry_out(bcd_carry)
  );

  // Flag image after BCD correction; V left as it was (undefined)
  always_comb begin
    bcd_flags = flags_in;
    bcd_flags[`CIJBA_FLAG_C] = bcd_carry; // RQ14
    bcd_flags[`CIJBA_FLAG_Z] = (bcd_value == 8'h00); // RQ14
    bcd_flags[`CIJBA_FLAG_S] = bcd_value[7]; // RQ14
  end

  // Sequencer: counts the whole instruction length from the issue cycle
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      CIJBA_IDLE: begin
        if (take) begin
          state_d = CIJBA_RUN;
          if (is_bcd) begin
            cnt_d = `CIJBA_CYC_BCD - 5'h01; // RQ15
          end else if (br_taken) begin
            cnt_d = `CIJBA_CYC_TAKEN - 5'h01; // RQ8
          end else begin
            cnt_d = `CIJBA_CYC_NOT_TAKEN - 5'h01; // RQ8
          end
        end
      end
      CIJBA_RUN: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          state_d = CIJBA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= CIJBA_IDLE;
      cnt_q <= 5'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign finish = (state_q == CIJBA_RUN) && (cnt_q == 5'h01);

  // Results captured at issue so later operand changes cannot disturb them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      kind_jump_q <= 1'b0;
      pc_q <= 16'h0000;
      ptr_q <= 8'h00;
      dst_q <= 8'h00;
      dst_ind_q <= 1'b0;
      flags_q <= 8'h00;
      taken_q <= 1'b0;
    end else if (take) begin
      kind_jump_q <= is_jump;
      if (is_jump) begin
        pc_q <= br_pc; // RQ1
        ptr_q <= br_ptr; // RQ4
        taken_q <= br_taken; // RQ3
        flags_q <= flags_in; // RQ5
      end else begin
        pc_q <= pc_in;
        dst_q <= bcd_value; // RQ10
        dst_ind_q <= (opcode == `CIJBA_OP_BCD_IND); // RQ15
        flags_q <= bcd_flags; // RQ14
        taken_q <= 1'b0;
      end
    end
  end

  assign busy = (state_q == CIJBA_RUN);
  assign done = finish;
  assign pc_out = pc_q;
  assign ptr_out = ptr_q;
  assign dst_out = dst_q;
  assign dst_indirect = dst_ind_q;
  assign flags_out = flags_q;
  assign pc_we = finish; // RQ2
  assign ptr_we = finish && kind_jump_q; // RQ4
  assign dst_we = finish && !kind_jump_q; // RQ10
  // Compare-jump never writes the flag register
  assign flags_we = finish && !kind_jump_q; // RQ5

  // Control register: enable bit gates issue
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= `CIJBA_CTRL_RESET;
    end else if (reg_we && (reg_addr == `CIJBA_ADDR_CTRL)) begin
      ctrl_q <= reg_wdata;
    end
  end

  // Status: busy is busy registered one cycle late, taken records the last jump, bad opcode is sticky
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else begin
      status_q[`CIJBA_ST_BUSY] <= busy;
      if (finish && kind_jump_q) begin
        status_q[`CIJBA_ST_TAKEN] <= taken_q;
      end
      // A new bad opcode in the clearing cycle is kept
      if (bad_take) begin
        status_q[`CIJBA_ST_BAD_OP] <= 1'b1;
      end else if (reg_we && (reg_addr == `CIJBA_ADDR_STATUS) && reg_wdata[`CIJBA_ST_BAD_OP]) begin
        status_q[`CIJBA_ST_BAD_OP] <= 1'b0;
      end
    end
  end

  // Taken-branch counter; increment wins over a clearing write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      taken_cnt_q <= 8'h00;
    end else if (finish && kind_jump_q && taken_q) begin
      taken_cnt_q <= taken_cnt_q + 8'h01;
    end else if (reg_we && (reg_addr == `CIJBA_ADDR_TAKEN_CNT)) begin
      taken_cnt_q <= 8'h00;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        `CIJBA_ADDR_CTRL: reg_rdata_q <= ctrl_q;
        `CIJBA_ADDR_STATUS: reg_rdata_q <= status_q;
        `CIJBA_ADDR_TAKEN_CNT: reg_rdata_q <= taken_cnt_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule
`default_nettype wire

// File: hdl/cijba_consts.svh
/*
  Constants for the compare-increment-jump and BCD correction datapath:
  opcodes, cycle counts, flag bit positions, register offsets, reset values.
  Assumes inclusion by every design file that needs them; definitions only.
*/
`ifndef CIJBA_CONSTS_SVH
`define CIJBA_CONSTS_SVH

`define CIJBA_OP_JUMP_EQ 8'hC2
`define CIJBA_OP_JUMP_NE 8'hD2
`define CIJBA_OP_BCD_REG 8'h40
`define CIJBA_OP_BCD_IND 8'h41

`define CIJBA_CYC_TAKEN 5'h12
`define CIJBA_CYC_NOT_TAKEN 5'h10
`define CIJBA_CYC_BCD 5'h04

`define CIJBA_FLAG_C 7
`define CIJBA_FLAG_Z 6
`define CIJBA_FLAG_S 5
`define CIJBA_FLAG_V 4

`define CIJBA_ADDR_CTRL 8'h00
`define CIJBA_ADDR_STATUS 8'h04
`define CIJBA_ADDR_TAKEN_CNT 8'h08
`define CIJBA_CTRL_RESET 8'h01
`define CIJBA_CTRL_EN 0
`define CIJBA_ST_BUSY 0
`define CIJBA_ST_TAKEN 1
`define CIJBA_ST_BAD_OP 2

`define CIJBA_ADD_NONE 8'h00
`define CIJBA_ADD_LO 8'h06
`define CIJBA_ADD_HI 8'h60
`define CIJBA_ADD_BOTH 8'h66
`define CIJBA_SUB_LO 8'hFA
`define CIJBA_SUB_HI 8'hA0
`define CIJBA_SUB_BOTH 8'h9A

`endif

// File: hdl/cijba_pkg.sv
/*
  Types shared by the datapath modules: controller states and nibble range test.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cijba_pkg;

  typedef enum logic [1:0] {
    CIJBA_IDLE,
    CIJBA_RUN
  } cijba_state_e;

  typedef logic [7:0] cijba_byte_t;

  // Inclusive range test on one BCD digit position
  function automatic logic cijba_in_range(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
    cijba_in_range = (v >= lo) && (v <= hi);
  endfunction

endpackage
`default_nettype wire

// File: hdl/cijba_bcd_adjust.sv
/*
  Combinational BCD correction of one byte after an addition or subtraction.
  Assumes carry and half-carry are the flags left by the preceding arithmetic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cijba_consts.svh"

module cijba_bcd_adjust (
  input wire logic [7:0] value,
  input wire logic carry_in,
  input wire logic half_in,
  input wire logic after_sub,
  output logic [7:0] result,
  output logic carry_out
);
  import cijba_pkg::*;

  logic [3:0] hi;
  logic [3:0] lo;
  logic [7:0] corr;

  assign hi = value[7:4];
  assign lo = value[3:0];

  always_comb begin
    // Invalid operands fall to no correction, carry kept
    corr = `CIJBA_ADD_NONE;
    carry_out = carry_in; // RQ13
    if (!after_sub) begin // RQ16
      if (!carry_in && cijba_in_range(hi, 4'h0, 4'h9) && !half_in && cijba_in_range(lo, 4'h0, 4'h9)) begin
        corr = `CIJBA_ADD_NONE;
        carry_out = 1'b0; // RQ11
      end else if (!carry_in && cijba_in_range(hi, 4'h0, 4'h8) && !half_in && cijba_in_range(lo, 4'hA, 4'hF)) begin
        corr = `CIJBA_ADD_LO;
        carry_out = 1'b0; // RQ11
      end else if (!carry_in && cijba_in_range(hi, 4'h0, 4'h9) && half_in && cijba_in_range(lo, 4'h0, 4'h3)) begin
        corr = `CIJBA_ADD_LO;
        carry_out = 1'b0; // RQ11
      end else if (!carry_in && cijba_in_range(hi, 4'hA, 4'hF) && !half_in && cijba_in_range(lo, 4'h0, 4'h9)) begin
        corr = `CIJBA_ADD_HI;
        carry_out = 1'b1; // RQ11
      end else if (!carry_in && cijba_in_range(hi, 4'h9, 4'hF) && !half_in && cijba_in_range(lo, 4'hA, 4'hF)) begin
        corr = `CIJBA_ADD_BOTH;
        carry_out = 1'b1; // RQ11
      end else if (!carry_in && cijba_in_range(hi, 4'hA, 4'hF) && half_in && cijba_in_range(lo, 4'h0, 4'h3)) begin
        corr = `CIJBA_ADD_BOTH;
        carry_out = 1'b1; // RQ11
      end else if (carry_in && cijba_in_range(hi, 4'h0, 4'h2) && !half_in && cijba_in_range(lo, 4'h0, 4'h9)) begin
        corr = `CIJBA_ADD_HI;
        carry_out = 1'b1; // RQ11
      end else if (carry_in && cijba_in_range(hi, 4'h0, 4'h2) && !half_in && cijba_in_range(lo, 4'hA, 4'hF)) begin
        corr = `CIJBA_ADD_BOTH;
        carry_out = 1'b1; // RQ11
      end else if (carry_in && cijba_in_range(hi, 4'h0, 4'h3) && half_in && cijba_in_range(lo, 4'h0, 4'h3)) begin
        corr = `CIJBA_ADD_BOTH;
        carry_out = 1'b1; // RQ11
      end
    end else begin
      if (!carry_in && cijba_in_range(hi, 4'h0, 4'h9) && !half_in && cijba_in_range(lo, 4'h0, 4'h9)) begin
        corr = `CIJBA_ADD_NONE;
        carry_out = 1'b0; // RQ12
      end else if (!carry_in && cijba_in_range(hi, 4'h0, 4'h8) && half_in && cijba_in_range(lo, 4'h6, 4'hF)) begin
        corr = `CIJBA_SUB_LO;
        carry_out = 1'b0; // RQ12
      end else if (carry_in && cijba_in_range(hi, 4'h7, 4'hF) && !half_in && cijba_in_range(lo, 4'h0, 4'h9)) begin
        corr = `CIJBA_SUB_HI;
        carry_out = 1'b1; // RQ12
      end else if (carry_in && cijba_in_range(hi, 4'h6, 4'hF) && half_in && cijba_in_range(lo, 4'h6, 4'hF)) begin
        corr = `CIJBA_SUB_BOTH;
        carry_out = 1'b1; // RQ12
      end
    end
  end

  // Correction is a plain 8-bit add; the wrap-around is intended
  assign result = value + corr; // RQ10

endmodule
`default_nettype wire

// File: hdl/cijba_branch_unit.sv
/*
  Combinational compare, pointer increment and relative target for the
  fused compare-jump instructions. Assumes pc is the address after the
  three-byte instruction.
*/
`timescale 1ns/1ps
`default_nettype none

module cijba_branch_unit (
  input wire logic [7:0] dst_value,
  input wire logic [7:0] src_value,
  input wire logic [7:0] src_ptr,
  input wire logic [7:0] branch_offset,
  input wire logic [15:0] pc,
  input wire logic jump_on_equal,
  output logic taken,
  output logic [15:0] pc_next,
  output logic [7:0] ptr_next
);
  import cijba_pkg::*;

  logic [7:0] diff;
  logic [15:0] offset_ext;

  // Difference only steers the branch and is never stored
  assign diff = dst_value - src_value; // RQ1
  assign taken = jump_on_equal ? (diff == 8'h00) : (diff != 8'h00); // RQ3
  assign offset_ext = {{8{branch_offset[7]}}, branch_offset}; // RQ9
  assign pc_next = taken ? pc + offset_ext : pc; // RQ2
  assign ptr_next = src_ptr + 8'h01; // RQ4

endmodule
`default_nettype wire

// File: dv/cijba_core_props.sv
/*
  Concurrent checks on the ports of cijba_core.
  Assumes one clock domain and binding from the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cijba_consts.svh"
module cijba_core_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic issue,
  input wire cijba_pkg::cijba_byte_t opcode,
  input wire cijba_pkg::cijba_byte_t dst_value,
  input wire cijba_pkg::cijba_byte_t src_value,
  input wire cijba_pkg::cijba_byte_t src_ptr,
  input wire cijba_pkg::cijba_byte_t branch_offset,
  input wire logic [15:0] pc_in,
  input wire cijba_pkg::cijba_byte_t flags_in,
  input wire logic reg_re,
  input wire logic busy,
  input wire logic done,
  input wire logic accept,
  input wire logic [15:0] pc_out,
  input wire logic pc_we,
  input wire logic [7:0] ptr_out,
  input wire logic ptr_we,
  input wire logic [7:0] dst_out,
  input wire logic dst_we,
  input wire logic [7:0] flags_out,
  input wire logic flags_we,
  input wire logic [7:0] reg_rdata
);
  import cijba_pkg::*;
  logic go;
  logic is_bcd;
  logic is_jmp;
  logic jtake;
  logic [15:0] exp_pc_q;
  logic [7:0] exp_ptr_q;
  logic [7:0] exp_flg_q;
  assign go = issue && accept;
  assign is_bcd = opcode == `CIJBA_OP_BCD_REG || opcode == `CIJBA_OP_BCD_IND;
  assign is_jmp = opcode == `CIJBA_OP_JUMP_EQ || opcode == `CIJBA_OP_JUMP_NE;
  assign jtake = (opcode == `CIJBA_OP_JUMP_EQ) == (dst_value == src_value);
  // Expected results latched at the accepting edge, since latency varies
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      exp_pc_q <= 16'h0000;
      exp_ptr_q <= 8'h00;
      exp_flg_q <= 8'h00;
    end else if (go) begin
      exp_pc_q <= (is_jmp && jtake) ? pc_in + {{8{branch_offset[7]}}, branch_offset} : pc_in;
      exp_ptr_q <= src_ptr + 8'h01;
      exp_flg_q <= flags_in;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence jump_go_s(t);
    go && is_jmp && jtake == t;
  endsequence
  bcd_latency_a: assert property (go && is_bcd |-> ##1 busy ##2 done && dst_we && flags_we && !ptr_we)
    else $error("bcd correction latency or strobes wrong");
  jump_taken_a: assert property (jump_go_s(1'b1) |-> ##16 !done ##1 done && ptr_we)
    else $error("taken jump not finished in 18 cycles");
  jump_skip_a: assert property (jump_go_s(1'b0) |-> ##14 !done ##1 done && ptr_we)
    else $error("untaken jump not finished in 16 cycles");
  jump_flags_a: assert property (ptr_we |-> !flags_we && !dst_we)
    else $error("jump wrote flags or destination");
  pc_target_a: assert property (pc_we |-> done && pc_out == exp_pc_q)
    else $error("program counter result wrong");
  ptr_incr_a: assert property (ptr_we |-> ptr_out == exp_ptr_q)
    else $error("source pointer not incremented");
  bcd_flags_a: assert property (flags_we |->
    flags_out[6] == (dst_out == 8'h00) && flags_out[5] == dst_out[7] && flags_out[4:0] == exp_flg_q[4:0])
    else $error("bcd flag update wrong");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  busy_refuse_a: assert property (busy |-> !accept)
    else $error("accept while busy");
  rdata_quiet_a: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data without read strobe");
endmodule
`default_nettype wire

// File: dv/testbench.sv
/*
  Self-checking bench for cijba_core: jumps, bcd correction, refusals, registers.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cijba_consts.svh"
module testbench;
  import cijba_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, issue = 1'b0, sub_flag = 1'b0, half_flag = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  cijba_byte_t opcode = 8'h00, dst_value = 8'h00, src_value = 8'h00, src_ptr = 8'h00;
  cijba_byte_t branch_offset = 8'h00, flags_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic busy, done, accept, pc_we, ptr_we, dst_we, dst_indirect, flags_we;
  logic [15:0] pc_out;
  logic [7:0] ptr_out, dst_out, flags_out, reg_rdata;
  int err_count = 0, check_count = 0, cycles = 0, n;
  // Case tables, entry 0 at the right
  localparam logic [3:0][7:0] jop = {8'hD2, 8'hD2, 8'hC2, 8'hC2};
  localparam logic [3:0][7:0] jd = {8'h33, 8'h02, 8'h05, 8'h02};
  localparam logic [3:0][7:0] js = {8'h33, 8'h04, 8'h06, 8'h02};
  localparam logic [3:0][7:0] jp = {8'h10, 8'h03, 8'hFF, 8'h03};
  localparam logic [3:0][7:0] jo = {8'h05, 8'h80, 8'h80, 8'h7F};
  localparam logic [3:0][15:0] jpc = {16'h2222, 16'h0005, 16'h1000, 16'h1000};
  localparam logic [9:0][7:0] bv = {8'h00, 8'h6F, 8'h91, 8'h2B, 8'h79, 8'h15, 8'hA2, 8'h9C, 8'hA5, 8'h3C};
  localparam logic [9:0][7:0] br = {8'h00, 8'h09, 8'h31, 8'h25, 8'h79, 8'h75, 8'h08, 8'h02, 8'h05, 8'h42};
  localparam logic [9:0] bc = 10'b0110010000;
  localparam logic [9:0] bh = 10'b0101001000;
  localparam logic [9:0] bs = 10'b1111000000;
  localparam logic [9:0] bco = 10'b0110011110;
  always #10 clk_sys = ~clk_sys;
  cijba_core u_cijba_core (.clk_sys(clk_sys), .rst_n(rst_n), .issue(issue), .opcode(opcode),
    .dst_value(dst_value), .src_value(src_value), .src_ptr(src_ptr), .branch_offset(branch_offset),
    .pc_in(pc_in), .flags_in(flags_in), .sub_flag(sub_flag), .half_flag(half_flag), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .busy(busy), .done(done), .accept(accept),
    .pc_out(pc_out), .pc_we(pc_we), .ptr_out(ptr_out), .ptr_we(ptr_we), .dst_out(dst_out), .dst_we(dst_we),
    .dst_indirect(dst_indirect), .flags_out(flags_out), .flags_we(flags_we), .reg_rdata(reg_rdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Issues one instruction; n ends as the cycle of done, 40 if none came
  task automatic run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] p,
                     input logic [7:0] off, input logic [15:0] pc, input logic [7:0] f, input logic sb, input logic h);
    @(posedge clk_sys);
    issue <= 1'b1;
    opcode <= op;
    dst_value <= d;
    src_value <= s;
    src_ptr <= p;
    branch_offset <= off;
    pc_in <= pc;
    flags_in <= f;
    sub_flag <= sb;
    half_flag <= h;
    @(posedge clk_sys);
    issue <= 1'b0;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic s_jumps;
    logic t;
    for (int i = 0; i < 4; i++) begin
      run(jop[i], jd[i], js[i], jp[i], jo[i], jpc[i], 8'hA5, 1'b0, 1'b0);
      t = (jop[i] == `CIJBA_OP_JUMP_EQ) == (jd[i] == js[i]);
      chk(n[15:0], t ? 16'h0011 : 16'h000F);
      chk(pc_out, t ? jpc[i] + {{8{jo[i][7]}}, jo[i]} : jpc[i]);
      chk({ptr_we, ptr_out}, {1'b1, jp[i] + 8'h01});
      chk({flags_we, dst_we}, 2'b00);
    end
  endtask
  task automatic s_bcd;
    for (int i = 0; i < 10; i++) begin
      run(i[0] ? `CIJBA_OP_BCD_IND : `CIJBA_OP_BCD_REG, bv[i], 8'h00, 8'h00, 8'h00, 16'h0100, {bc[i], 7'h55},
          bs[i], bh[i]);
      chk({n[3:0], dst_indirect, ptr_we}, {4'h3, i[0], 1'b0});
      chk(dst_out, br[i]);
      chk(flags_out, {bco[i], br[i] == 8'h00, br[i][7], 5'h15});
    end
  endtask
  task automatic s_refuse_regs;
    logic [7:0] d;
    reg_wr(`CIJBA_ADDR_CTRL, 8'h00);
    run(`CIJBA_OP_BCD_REG, 8'h3C, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0);
    chk(n[15:0], 16'h0028);
    reg_wr(`CIJBA_ADDR_CTRL, 8'h01);
    run(8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0);
    reg_rd(`CIJBA_ADDR_STATUS, d);
    chk(d, 8'h04);
    reg_wr(`CIJBA_ADDR_STATUS, 8'h04);
    reg_rd(`CIJBA_ADDR_STATUS, d);
    chk(d, 8'h00);
    reg_rd(`CIJBA_ADDR_TAKEN_CNT, d);
    chk(d, 8'h02);
    reg_wr(`CIJBA_ADDR_TAKEN_CNT, 8'h00);
    reg_rd(`CIJBA_ADDR_TAKEN_CNT, d);
    chk(d, 8'h00);
    reg_rd(8'h0C, d);
    chk(d, 8'h00);
  endtask
  initial begin
    logic [7:0] d;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_rd(`CIJBA_ADDR_CTRL, d);
    chk(d, `CIJBA_CTRL_RESET);
    s_jumps();
    s_bcd();
    s_refuse_regs();
    wrap_up();
  end
endmodule
bind cijba_core cijba_core_props u_cijba_core_props (.clk_sys(clk_sys), .rst_n(rst_n), .issue(issue),
  .opcode(opcode), .dst_value(dst_value), .src_value(src_value), .src_ptr(src_ptr),
  .branch_offset(branch_offset), .pc_in(pc_in), .flags_in(flags_in), .reg_re(reg_re), .busy(busy),
  .done(done), .accept(accept), .pc_out(pc_out), .pc_we(pc_we), .ptr_out(ptr_out), .ptr_we(ptr_we),
  .dst_out(dst_out), .dst_we(dst_we), .flags_out(flags_out), .flags_we(flags_we), .reg_rdata(reg_rdata));
`default_nettype wire
